// file: rtl/fcb_pkg.sv
package fcb_pkg;
  // Address layout
  localparam int ADDR_W      = 10;              // Host address width
  localparam int DATA_W      = 8;               // Host data width
  localparam int REG_W       = 8;               // Register index width
  localparam int FRAMER_W    = 2;               // Framer select width
  localparam int MAX_FRAMERS = 4;               // Framers a port can serve
  // Bus style pin levels
  localparam logic STYLE_SEPARATE = 1'b0;       // Separate read and write strobes
  localparam logic STYLE_DSTROBE  = 1'b1;       // Data strobe plus direction
  // Direction line levels in data strobe style
  localparam logic DIR_READ  = 1'b1;            // Direction high reads
  localparam logic DIR_WRITE = 1'b0;            // Direction low writes
  // Read value of an absent framer
  localparam logic [7:0] ABSENT_READ = 8'h00;   // Absent block reads zero
  // Counter readback settle time
  localparam int UPDATE_SETTLE_NS = 100;        // Wait after update strobe
  localparam int CLK_PERIOD_NS    = 40;         // Port clock period
  localparam int UPDATE_SETTLE_CYC =
    (UPDATE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS; // Rounded up
  // Host access sequencer states
  typedef enum logic [2:0] {FCB_IDLE, FCB_ADDR, FCB_STROBE, FCB_HOLD, FCB_DONE} fcb_state_type;
endpackage

// file: rtl/fcb_if.sv
`timescale 1ns/1ps
interface fcb_if;
  import fcb_pkg::*;
  logic              bus_style_select;  // Strobe style
  logic [ADDR_W-1:0] addr;              // Host address
  logic              ale;               // Address latch enable
  logic              cs_n;              // Chip select
  logic              wr_n;              // Write strobe or direction
  logic              rd_n;              // Read strobe or data strobe
  logic [DATA_W-1:0] d_host;            // Data driven by host
  logic              d_host_oe;         // Host drives data
  logic [DATA_W-1:0] d_dev;             // Data driven by device
  logic              d_dev_oe;          // Device drives data
  logic              int_n_oe;          // Device pulls interrupt low
  logic              counter_update_in; // Counter update strobe
  wire  [DATA_W-1:0] d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : {DATA_W{1'b1}});
  wire               int_n = ~int_n_oe;
  modport device (input bus_style_select, addr, ale, cs_n, wr_n, rd_n, d_host, d_host_oe,
                  counter_update_in, output d_dev, d_dev_oe, int_n_oe);
  modport host (output bus_style_select, addr, ale, cs_n, wr_n, rd_n, d_host, d_host_oe,
                counter_update_in, input d_dev, d_dev_oe, int_n_oe, d_bus, int_n);
endinterface

// file: rtl/fcb_device.sv
`timescale 1ns/1ps
// Contract
// - Style pin: low separate, high data strobe
// - Drive data only during reads; the device still drives for one cycle after the strobe releases
// - Top two address bits pick framer
// - Host muxes address, valid at latch fall
// - Latch transparent high, holds on fall
// - Nonmuxed host keeps latch enable high
// - Strobes count only with chip select
// - Separate style: write and read strobes
// - Data strobe; direction high read
// - Interrupt low while unmasked source active
// - Host supplies continuous ungapped port clock
// - Port timing uses system clock only
// - Selected external strobe edge loads counters
// - Host drops strobe before next update
// - Host waits 100 ns before reading counters
// - External strobe ORed with manual bit
// - Unused update strobe tied low
// - Each framer owns a 256-byte block
// - Absent framer: writes ignored, reads zero
module fcb_device
  import fcb_pkg::*;
#(
  parameter int NUM_FRAMERS = 4                // Framers present
)(
  input  wire logic              MCLK,              // System clock
  input  wire logic              RESETN,            // Synchronous reset
  fcb_if.device                  bus,               // Host side
  input  wire logic [DATA_W-1:0] RD_DATA,           // Register file read data
  input  wire logic [NUM_FRAMERS-1:0] IRQ_ACTIVE,   // Unmasked sources per framer
  input  wire logic              AUTO_COUNTER_UPDATE_SEL, // External strobe chosen
  input  wire logic              MANUAL_COUNTER_UPDATE,   // Manual update bit
  output logic [FRAMER_W-1:0]    FRAMER_SEL,        // Decoded framer
  output logic [REG_W-1:0]       REG_ADDR,          // Decoded register
  output logic                   WR_STB,            // Write pulse
  output logic [DATA_W-1:0]      WR_DATA,           // Write data
  output logic                   RD_STB,            // Read start pulse
  output logic                   COUNTER_LOAD       // Load pulse to all framers
);
  ////////////////////////////////////////////////////////////////////////////////
  // Parameter check
  // Refuse framer counts the two select bits cannot reach
  if (NUM_FRAMERS < 1 || NUM_FRAMERS > MAX_FRAMERS)
  begin : g_bad_framers
    $error("NUM_FRAMERS out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address latch
  logic [ADDR_W-1:0] addr_hold_reg;             // Held address
  logic [ADDR_W-1:0] addr_eff;                  // Latch output
  // Follows the pins while latch enable is high, so the last
  // value before the falling edge is the one kept
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      addr_hold_reg <= '0;
    else if (bus.ale)
      addr_hold_reg <= bus.addr;
  end
  // Transparent while high, holds after fall
  assign addr_eff = bus.ale ? bus.addr : addr_hold_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe decode
  logic rd_act;                                 // Read requested
  logic wr_act;                                 // Write requested
  logic present;                                // Framer exists
  // Level of a selected access, before edge detection
  // Strobes outside chip select count for nothing
  always_comb
  begin
    if (bus.bus_style_select == STYLE_DSTROBE)
    begin
      rd_act = !bus.rd_n && bus.wr_n == DIR_READ;
      wr_act = !bus.rd_n && bus.wr_n == DIR_WRITE;
    end
    else
    begin
      rd_act = !bus.rd_n;
      wr_act = !bus.wr_n;
    end
    rd_act = rd_act && !bus.cs_n;
    wr_act = wr_act && !bus.cs_n;
  end
  // Framer index below the fitted count
  assign present = 32'(addr_eff[ADDR_W-1 -: FRAMER_W]) < NUM_FRAMERS;

  ////////////////////////////////////////////////////////////////////////////////
  // Access pulses on strobe assertion
  logic rd_act_d_reg;                           // Previous read level
  logic wr_act_d_reg;                           // Previous write level
  // Strobe history for edge detection
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      rd_act_d_reg <= 1'b0;
      wr_act_d_reg <= 1'b0;
    end
    else
    begin
      rd_act_d_reg <= rd_act;
      wr_act_d_reg <= wr_act;
    end
  end

  // One pulse per access, however long the strobe stands
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      WR_STB <= 1'b0;
      RD_STB <= 1'b0;
    end
    else
    begin
      // Accesses to an absent framer raise no pulse
      WR_STB <= wr_act && !wr_act_d_reg && present;
      RD_STB <= rd_act && !rd_act_d_reg && present;
    end
  end

  // Decoded address and write data, tracked every cycle
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      FRAMER_SEL <= '0;
      REG_ADDR   <= '0;
      WR_DATA    <= '0;
    end
    else
    begin
      FRAMER_SEL <= addr_eff[ADDR_W-1 -: FRAMER_W];
      REG_ADDR   <= addr_eff[REG_W-1:0];
      WR_DATA    <= bus.d_host;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data drive, timed by the system clock
  // Bus follows the strobe one cycle late, so it is
  // still driven for one cycle after the strobe releases
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      bus.d_dev    <= '0;
      bus.d_dev_oe <= 1'b0;
    end
    else
    begin
      bus.d_dev_oe <= rd_act;
      bus.d_dev    <= present ? RD_DATA : ABSENT_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt pull-down
  // Open drain: only ever pulls low, never drives high
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      bus.int_n_oe <= 1'b0;
    else
      bus.int_n_oe <= |IRQ_ACTIVE;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter update strobe synchroniser and edge detect
  logic upd_s1_reg;                             // First sync stage
  logic upd_s2_reg;                             // Second sync stage
  logic upd_s3_reg;                             // Edge history
  logic man_d_reg;                              // Manual bit history
  logic trig;                                   // Combined trigger
  // Strobe is asynchronous; only the second stage
  // is read onward, the first may be metastable
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      upd_s1_reg <= 1'b0;
      upd_s2_reg <= 1'b0;
      upd_s3_reg <= 1'b0;
      man_d_reg  <= 1'b0;
    end
    else
    begin
      upd_s1_reg <= bus.counter_update_in;
      upd_s2_reg <= upd_s1_reg;
      upd_s3_reg <= upd_s2_reg;
      man_d_reg  <= MANUAL_COUNTER_UPDATE;
    end
  end
  // Each source edge detected; the manual edge loads, the strobe edge only when selected
  assign trig = (AUTO_COUNTER_UPDATE_SEL && upd_s2_reg && !upd_s3_reg)
              || (MANUAL_COUNTER_UPDATE && !man_d_reg);

  // Load pulse to every framer
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      COUNTER_LOAD <= 1'b0;
    else
      COUNTER_LOAD <= trig;
  end
endmodule // fcb_device

// file: rtl/fcb_host.sv
`timescale 1ns/1ps
module fcb_host
  import fcb_pkg::*;
(
  input  wire logic              MCLK,        // Host clock
  input  wire logic              RESETN,      // Synchronous reset
  fcb_if.host                    bus,         // Device side
  input  wire logic              STYLE,       // Chosen strobe style
  input  wire logic              MUXED,       // Multiplexed addressing
  input  wire logic              REQ,         // Start access
  input  wire logic              REQ_WRITE,   // Access is a write
  input  wire logic [ADDR_W-1:0] REQ_ADDR,    // Access address
  input  wire logic [DATA_W-1:0] REQ_WDATA,   // Write data
  input  wire logic              UPDATE,      // Request counter update
  output logic                   BUSY,        // Access in progress
  output logic                   DONE,        // Access finished pulse
  output logic [DATA_W-1:0]      RDATA,       // Read result
  output logic                   COUNTERS_READY, // Counters safe to read
  output logic                   IRQ          // Interrupt seen
);
  fcb_state_type state_reg;                   // Sequencer state
  logic          wr_reg;                      // Latched direction
  logic [1:0]    upd_cnt_reg;                 // Settle counter

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      state_reg            <= FCB_IDLE;
      wr_reg               <= 1'b0;
      bus.bus_style_select <= STYLE_SEPARATE;
      bus.addr             <= '0;
      bus.ale              <= 1'b1;
      bus.cs_n             <= 1'b1;
      bus.wr_n             <= 1'b1;
      bus.rd_n             <= 1'b1;
      bus.d_host           <= '0;
      bus.d_host_oe        <= 1'b0;
      BUSY                 <= 1'b0;
      DONE                 <= 1'b0;
      RDATA                <= '0;
    end
    else
    begin
      bus.bus_style_select <= STYLE;
      DONE <= 1'b0;
      unique case (state_reg)
        FCB_IDLE:
        begin
          bus.ale <= 1'b1;
          if (REQ)
          begin
            state_reg <= FCB_ADDR;
            wr_reg    <= REQ_WRITE;
            BUSY      <= 1'b1;
            bus.addr  <= REQ_ADDR;
            // Muxed: address also on data lines
            bus.d_host    <= MUXED ? REQ_ADDR[DATA_W-1:0] : REQ_WDATA;
            bus.d_host_oe <= MUXED || REQ_WRITE;
          end
        end
        FCB_ADDR:
        begin
          if (MUXED)
          begin
            bus.ale              <= 1'b0;
            // Shared lines now carry data, the latch keeps the address
            bus.addr[DATA_W-1:0] <= REQ_WDATA;
          end
          bus.d_host    <= REQ_WDATA;
          bus.d_host_oe <= wr_reg;
          // Strobes lead chip select, the device must ignore them
          if (STYLE == STYLE_DSTROBE)
          begin
            bus.wr_n <= wr_reg ? DIR_WRITE : DIR_READ;
            bus.rd_n <= 1'b0;
          end
          else
          begin
            bus.wr_n <= !wr_reg;
            bus.rd_n <= wr_reg;
          end
          state_reg     <= FCB_STROBE;
        end
        FCB_STROBE:
        begin
          bus.cs_n  <= 1'b0;
          state_reg <= FCB_HOLD;
        end
        FCB_HOLD:
        begin
          // Device answers one cycle after select
          state_reg <= FCB_DONE;
        end
        FCB_DONE:
        begin
          RDATA         <= bus.d_bus;
          bus.rd_n      <= 1'b1;
          bus.wr_n      <= 1'b1;
          bus.cs_n      <= 1'b1;
          bus.d_host_oe <= 1'b0;
          bus.ale       <= 1'b1;
          BUSY          <= 1'b0;
          DONE          <= 1'b1;
          state_reg     <= FCB_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter update strobe: one clock high then low, then settle wait
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
    begin
      bus.counter_update_in <= 1'b0;
      upd_cnt_reg           <= '0;
      COUNTERS_READY        <= 1'b1;
    end
    else if (UPDATE && !bus.counter_update_in && COUNTERS_READY)
    begin
      bus.counter_update_in <= 1'b1;
      upd_cnt_reg           <= 2'(UPDATE_SETTLE_CYC);
      COUNTERS_READY        <= 1'b0;
    end
    else
    begin
      bus.counter_update_in <= 1'b0;
      if (upd_cnt_reg != '0)
        upd_cnt_reg <= upd_cnt_reg - 2'h1;
      else
        COUNTERS_READY <= 1'b1;
    end
  end

  // Interrupt level
  always_ff @(posedge MCLK)
  begin
    if (!RESETN)
      IRQ <= 1'b0;
    else
      IRQ <= !bus.int_n;
  end
endmodule // fcb_host

// file: testbench/fcb_checker.sv
`timescale 1ns/1ps
module fcb_checker
  import fcb_pkg::*;
(
  input  wire logic MCLK,             // Port clock
  input  wire logic RESETN,           // Synchronous reset
  input  wire logic bus_style_select, // Strobe style
  input  wire logic cs_n,             // Chip select
  input  wire logic wr_n,             // Write strobe or direction
  input  wire logic rd_n,             // Read strobe or data strobe
  input  wire logic d_host_oe,        // Host drives data
  input  wire logic d_dev_oe          // Device drives data
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////
  // Device drives only after a selected read
  property p_dev_drive_read;
    d_dev_oe |-> $past(!cs_n && !rd_n && (bus_style_select == STYLE_SEPARATE || wr_n == DIR_READ));
  endproperty
  a_dev_drive_read: assert property (p_dev_drive_read)
    else $error("data driven outside a read");
  // Never both ends on the data bus
  property p_no_contention;
    !(d_dev_oe && d_host_oe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("data bus contention");
  // Separate style read answers next cycle
  property p_sep_read;
    bus_style_select == STYLE_SEPARATE && !cs_n && !rd_n |=> d_dev_oe;
  endproperty
  a_sep_read: assert property (p_sep_read)
    else $error("separate read not driven");
  // Separate style write leaves bus alone
  property p_sep_write;
    bus_style_select == STYLE_SEPARATE && !cs_n && !wr_n && rd_n |=> !d_dev_oe;
  endproperty
  a_sep_write: assert property (p_sep_write)
    else $error("separate write drove bus");
  // Data strobe with direction high reads
  property p_ds_read;
    bus_style_select == STYLE_DSTROBE && !cs_n && !rd_n && wr_n == DIR_READ |=> d_dev_oe;
  endproperty
  a_ds_read: assert property (p_ds_read)
    else $error("strobed read not driven");
  // Data strobe with direction low writes
  property p_ds_write;
    bus_style_select == STYLE_DSTROBE && !cs_n && !rd_n && wr_n == DIR_WRITE |=> !d_dev_oe;
  endproperty
  a_ds_write: assert property (p_ds_write)
    else $error("strobed write drove bus");
  // Device deselected for two cycles stays off the bus
  property p_cs_ignore;
    cs_n [*2] |-> !d_dev_oe [*2];
  endproperty
  a_cs_ignore: assert property (p_cs_ignore)
    else $error("driven while deselected");
  // Strobe release frees the bus
  property p_release;
    $rose(rd_n) |=> !d_dev_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("bus held after strobe release");
endmodule // fcb_checker

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fcb_pkg::*;
  ////////////////////////////////////////////////////////////
  logic                mclk, resetn, style, muxed, req, req_write;   // Host controls
  logic                update, auto_sel, manual_upd;                 // Counter controls
  logic [ADDR_W-1:0]   req_addr;                                     // Access address
  logic [DATA_W-1:0]   req_wdata, wr_data, rd_data, rdata;           // Data paths
  logic [2:0]          irq_active;                                   // Interrupt sources
  logic [FRAMER_W-1:0] framer_sel;                                   // Decoded framer
  logic [REG_W-1:0]    reg_addr;                                     // Decoded register
  logic                wr_stb, rd_stb, counter_load, busy, done, counters_ready, irq;
  logic [17:0]         wr_seen;                                      // Last write seen
  int                  fails, checked, wr_cnt, ld_cnt, rd_cnt;       // Counters
  fcb_if u_fcb_if();
  fcb_device #(.NUM_FRAMERS(3)) u_fcb_device (.MCLK(mclk), .RESETN(resetn),
    .bus(u_fcb_if.device), .RD_DATA(rd_data), .IRQ_ACTIVE(irq_active),
    .AUTO_COUNTER_UPDATE_SEL(auto_sel), .MANUAL_COUNTER_UPDATE(manual_upd),
    .FRAMER_SEL(framer_sel), .REG_ADDR(reg_addr), .WR_STB(wr_stb), .WR_DATA(wr_data),
    .RD_STB(rd_stb), .COUNTER_LOAD(counter_load));
  fcb_host u_fcb_host (.MCLK(mclk), .RESETN(resetn), .bus(u_fcb_if.host), .STYLE(style),
    .MUXED(muxed), .REQ(req), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .UPDATE(update), .BUSY(busy), .DONE(done), .RDATA(rdata),
    .COUNTERS_READY(counters_ready), .IRQ(irq));
  fcb_checker u_fcb_checker (.MCLK(mclk), .RESETN(resetn),
    .bus_style_select(u_fcb_if.bus_style_select), .cs_n(u_fcb_if.cs_n),
    .wr_n(u_fcb_if.wr_n), .rd_n(u_fcb_if.rd_n), .d_host_oe(u_fcb_if.d_host_oe),
    .d_dev_oe(u_fcb_if.d_dev_oe));
  ////////////////////////////////////////////////////////////
  // Register file stand-in, value from framer and register
  assign rd_data = {framer_sel, 6'h00} ^ reg_addr;
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Write and load monitors
  always @(posedge mclk)
  begin
    if (wr_stb === 1'b1)
    begin
      wr_cnt++;
      wr_seen = {framer_sel, reg_addr, wr_data};
    end
    if (counter_load === 1'b1)
      ld_cnt++;
    if (rd_stb === 1'b1)
      rd_cnt++;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  // One host access, judged at completion
  task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n0;
    int r0;
    n0 = wr_cnt;
    r0 = rd_cnt;
    @(negedge mclk);
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge mclk);
    req = 1'b0;
    chk(busy, 1'b1);
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge mclk);
    chk(done, 1'b1);
    chk(busy, 1'b0);
    if (!wr)
    begin
      chk(rdata, (a[9:8] == 2'h3) ? ABSENT_READ : {a[9:8], 6'h00} ^ a[7:0]);
      chk(18'(rd_cnt - r0), (a[9:8] == 2'h3) ? 18'h0 : 18'h1);
    end
    else
      chk(18'(wr_cnt - n0), (a[9:8] == 2'h3) ? 18'h0 : 18'h1);
    if (wr && a[9:8] != 2'h3)
      chk(wr_seen, {a, d});
  endtask
  // Counter update through strobe or manual bit
  task automatic upd_test(input logic sel, input logic man, input int exp);
    int n0;
    n0 = ld_cnt;
    @(negedge mclk);
    auto_sel = sel;
    update = 1'b1;
    manual_upd = man;
    @(negedge mclk);
    update = 1'b0;
    chk(counters_ready, 1'b0);
    repeat (2) @(negedge mclk);
    chk(counters_ready, 1'b0);
    repeat (8) @(negedge mclk);
    chk(18'(ld_cnt - n0), 18'(exp));
    chk(counters_ready, 1'b1);
    chk(u_fcb_if.counter_update_in, 1'b0);
    manual_upd = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  // Interrupt follows unmasked sources
  task automatic irq_test(input logic [2:0] src);
    @(negedge mclk);
    irq_active = src;
    repeat (3) @(negedge mclk);
    chk(u_fcb_if.int_n, ~|src);
    chk(irq, |src);
  endtask
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    fails++;
    complete_run;
  end
  // Main sequence
  initial
  begin
    {resetn, style, muxed, req, req_write, update, auto_sel, manual_upd} = 8'h00;
    req_addr = 10'h000;
    req_wdata = 8'h00;
    irq_active = 3'h0;
    {fails, checked, wr_cnt, ld_cnt, rd_cnt} = '0;
    repeat (20) @(negedge mclk);
    resetn = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      style = s[0];
      muxed = s[1];
      for (int f = 0; f < 4; f++)
      begin
        access(1'b1, {f[1:0], 8'hff}, 8'h5a ^ 8'(s));
        access(1'b0, {f[1:0], 8'h81}, 8'h00);
        access(1'b0, {f[1:0], 8'h00}, 8'h00);
      end
    end
    upd_test(1'b1, 1'b0, 1);
    upd_test(1'b0, 1'b0, 0);
    upd_test(1'b0, 1'b1, 1);
    irq_test(3'h1);
    irq_test(3'h4);
    irq_test(3'h0);
    complete_run;
  end
endmodule // testbench
